// *** rtl/tzoa_pkg.sv ***
// package for the zone temperature offset stage
// assumes an 8-bit register port and 8-bit two's complement readings
package tzoa_pkg;

    localparam logic [7:0] TZOA_ZONE1_OFFSET_ADDR = 8'hEE;
    localparam logic [7:0] TZOA_ZONE2_OFFSET_ADDR = 8'hEF;
    localparam logic [7:0] TZOA_OFFSET_RESET = 8'h00;
    localparam int TZOA_FIELD_LSB = 0;
    localparam int TZOA_FIELD_MSB = 5;
    localparam int TZOA_FIELD_W = 6;
    localparam int TZOA_TEMP_W = 8;
    localparam logic [7:0] TZOA_TEMP_MAX = 8'h7F;
    localparam logic [7:0] TZOA_TEMP_MIN = 8'h80;

    typedef struct packed {
        logic valid;
        logic [7:0] temp;
    } tzoa_meas_type;

    typedef struct packed {
        logic [5:0] zone1_offset_field;
        logic [5:0] zone2_offset_field;
        tzoa_meas_type zone1_out;
        tzoa_meas_type zone2_out;
        logic [7:0] rdata;
    } tzoa_state_type;

endpackage : tzoa_pkg

// *** rtl/tzoa_adder.sv ***
// saturating add of a 6-bit signed offset to an 8-bit signed reading
// assumes purely combinational use inside the offset stage
`timescale 1ns/1ps
module tzoa_adder (
    input wire logic [7:0] temp_i,
    input wire logic [5:0] offset_i,
    output logic [7:0] sum_o
);
    logic [8:0] wide;

    always_comb begin
        // sign-extend offset, add at 9 bits
        wide = {temp_i[7], temp_i} + {{3{offset_i[5]}}, offset_i};
        if (wide[8] != wide[7]) begin
            sum_o = wide[8] ? tzoa_pkg::TZOA_TEMP_MIN
                            : tzoa_pkg::TZOA_TEMP_MAX;
        end else begin
            sum_o = wide[7:0];
        end
    end
endmodule : tzoa_adder

// *** rtl/tzoa_offset.sv ***
// zone temperature offset stage with its two offset registers
// assumes readings arrive as one-cycle valid pulses on clk_sys_i
`timescale 1ns/1ps
module tzoa_offset (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire tzoa_pkg::tzoa_meas_type zone1_raw_i,
    input wire tzoa_pkg::tzoa_meas_type zone2_raw_i,
    output tzoa_pkg::tzoa_meas_type zone1_temp_o,
    output tzoa_pkg::tzoa_meas_type zone2_temp_o,
    output logic [5:0] zone1_offset_o,
    output logic [5:0] zone2_offset_o
);

    ////////////////////////////////////////////////////////////////////////
    tzoa_pkg::tzoa_state_type state;
    tzoa_pkg::tzoa_state_type next_state;
    logic [7:0] sum [2];
    logic [7:0] raw [2];
    logic [5:0] offs [2];

    assign raw[0] = zone1_raw_i.temp;
    assign raw[1] = zone2_raw_i.temp;
    assign offs[0] = state.zone1_offset_field;
    assign offs[1] = state.zone2_offset_field;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_zone
            tzoa_adder u_add (
                .temp_i(raw[g]),
                .offset_i(offs[g]),
                .sum_o(sum[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        if (reg_wr_i && reg_addr_i == tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR) begin
            // reserved bits dropped
            next_state.zone1_offset_field = reg_wdata_i[5:0];
        end
        if (reg_wr_i && reg_addr_i == tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR) begin
            next_state.zone2_offset_field = reg_wdata_i[5:0];
        end
        // corrected value replaces raw for all consumers
        next_state.zone1_out.valid = zone1_raw_i.valid;
        if (zone1_raw_i.valid) begin
            next_state.zone1_out.temp = sum[0];
        end
        next_state.zone2_out.valid = zone2_raw_i.valid;
        if (zone2_raw_i.valid) begin
            next_state.zone2_out.temp = sum[1];
        end
        case (reg_addr_i)
            tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR: begin
                next_state.rdata = {2'h0, state.zone1_offset_field};
            end
            tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR: begin
                next_state.rdata = {2'h0, state.zone2_offset_field};
            end
            default: begin
                next_state.rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= '0;
        end else if (clk_en_i) begin
            state <= next_state;
        end
    end

    assign reg_rdata_o = state.rdata;
    assign zone1_temp_o = state.zone1_out;
    assign zone2_temp_o = state.zone2_out;
    assign zone1_offset_o = state.zone1_offset_field;
    assign zone2_offset_o = state.zone2_offset_field;

    ////////////////////////////////////////////////////////////////////////
    // reference sums at ten bits, wide enough never to wrap
    logic signed [9:0] ref1;
    logic signed [9:0] ref2;

    assign ref1 = $signed({{2{zone1_raw_i.temp[7]}}, zone1_raw_i.temp})
                + $signed({{4{state.zone1_offset_field[5]}},
                           state.zone1_offset_field});
    assign ref2 = $signed({{2{zone2_raw_i.temp[7]}}, zone2_raw_i.temp})
                + $signed({{4{state.zone2_offset_field[5]}},
                           state.zone2_offset_field});

    ////////////////////////////////////////////////////////////////////////
    // corrected readings

    zone1_sum_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone1_raw_i.valid && ref1 < 10'sd128 && ref1 > -10'sd129
        |=> zone1_temp_o.valid && zone1_temp_o.temp == $past(ref1[7:0]))
        else $error("zone one sum wrong");

    zone2_sum_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone2_raw_i.valid && ref2 < 10'sd128 && ref2 > -10'sd129
        |=> zone2_temp_o.valid && zone2_temp_o.temp == $past(ref2[7:0]))
        else $error("zone two sum wrong");

    zone1_valid_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone1_raw_i.valid |=> zone1_temp_o.valid)
        else $error("zone one reading dropped");

    zone2_valid_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone2_raw_i.valid |=> zone2_temp_o.valid)
        else $error("zone two reading dropped");

    zone1_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && !zone1_raw_i.valid
        |=> !zone1_temp_o.valid && $stable(zone1_temp_o.temp))
        else $error("zone one output changed without reading");

    zone2_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && !zone2_raw_i.valid
        |=> !zone2_temp_o.valid && $stable(zone2_temp_o.temp))
        else $error("zone two output changed without reading");

    zero_pass_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone2_raw_i.valid && zone2_offset_o == 6'h00
        |=> zone2_temp_o.temp == $past(zone2_raw_i.temp))
        else $error("zero offset altered reading");

    neg_full_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone1_raw_i.valid && zone1_offset_o == 6'h20
        && zone1_raw_i.temp == 8'h40
        |=> zone1_temp_o.temp == 8'h20)
        else $error("minus 32 offset wrong");

    pos_full_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone2_raw_i.valid && zone2_offset_o == 6'h1F
        && zone2_raw_i.temp == 8'h40
        |=> zone2_temp_o.temp == 8'h5F)
        else $error("plus 31 offset wrong");

    sat1_high_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone1_raw_i.valid && ref1 > 10'sd127
        |=> zone1_temp_o.temp == tzoa_pkg::TZOA_TEMP_MAX)
        else $error("zone one high clamp wrong");

    sat1_low_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone1_raw_i.valid && ref1 < -10'sd128
        |=> zone1_temp_o.temp == tzoa_pkg::TZOA_TEMP_MIN)
        else $error("zone one low clamp wrong");

    sat2_high_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone2_raw_i.valid && ref2 > 10'sd127
        |=> zone2_temp_o.temp == tzoa_pkg::TZOA_TEMP_MAX)
        else $error("zone two high clamp wrong");

    sat2_low_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && zone2_raw_i.valid && ref2 < -10'sd128
        |=> zone2_temp_o.temp == tzoa_pkg::TZOA_TEMP_MIN)
        else $error("zone two low clamp wrong");

    ////////////////////////////////////////////////////////////////////////
    // offset registers, readback and freeze

    zone1_write_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && reg_wr_i
        && reg_addr_i == tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR
        |=> zone1_offset_o == $past(reg_wdata_i[5:0]))
        else $error("zone one offset write lost");

    field_write_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && reg_wr_i && reg_addr_i == 8'hEF
        |=> zone2_offset_o == $past(reg_wdata_i[5:0]))
        else $error("offset write lost");

    write_ignore_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && reg_wr_i
        && reg_addr_i != tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR
        && reg_addr_i != tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR
        |=> $stable(zone1_offset_o) && $stable(zone2_offset_o))
        else $error("foreign write moved an offset");

    rsvd_zero_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && reg_addr_i == tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR
        |=> reg_rdata_o == {2'h0, $past(zone1_offset_o)})
        else $error("zone one readback wrong");

    read_two_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && reg_addr_i == tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR
        |=> reg_rdata_o == {2'h0, $past(zone2_offset_o)})
        else $error("zone two readback wrong");

    read_other_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        clk_en_i && reg_addr_i != tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR
        && reg_addr_i != tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped address read nonzero");

    freeze_reg_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        !clk_en_i
        |=> $stable(zone1_offset_o) && $stable(zone2_offset_o)
        && $stable(reg_rdata_o))
        else $error("registers moved while frozen");

    freeze_out_a: assert property (
        @(posedge clk_sys_i) disable iff (!arst_n_i)
        !clk_en_i
        |=> $stable(zone1_temp_o) && $stable(zone2_temp_o))
        else $error("readings moved while frozen");

endmodule : tzoa_offset

// *** tb/tzoa_offset_tb_top.sv ***
// self-checking bench for the zone temperature offset stage
// assumes the fixed one-cycle latencies of the offset stage
`timescale 1ns/1ps
module tzoa_offset_tb_top;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    tzoa_pkg::tzoa_meas_type raw1 = '0;
    tzoa_pkg::tzoa_meas_type raw2 = '0;
    tzoa_pkg::tzoa_meas_type out1;
    tzoa_pkg::tzoa_meas_type out2;
    logic [5:0] off1;
    logic [5:0] off2;
    int error_cnt = 0;
    int compares = 0;
    logic clk_en_i = 1'b1;
    // each entry is {offset, reading}
    logic [13:0] cases [6] = '{14'h1F7F, 14'h2040, 14'h2080, 14'h01D0,
                               14'h207F, 14'h1F80};
    ////////////////////////////////////////////////////////////////////////
    tzoa_offset tzoa_offset_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .zone1_raw_i(raw1), .zone2_raw_i(raw2), .zone1_temp_o(out1),
        .zone2_temp_o(out2), .zone1_offset_o(off1), .zone2_offset_o(off2));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge clk_sys_i) #1;
        reg_wr_i = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i) #1;
        reg_addr_i = a;
        @(posedge clk_sys_i) #1;
        chk("rdata", e, reg_rdata_o);
    endtask : rd
    // saturating reference sum
    function automatic logic [7:0] ref_sum(logic [7:0] t, logic [5:0] o);
        int s;
        s = $signed(t) + $signed(o);
        if (s > 127) s = 127;
        if (s < -128) s = -128;
        return s[7:0];
    endfunction : ref_sum
    task t_regs;
        rd(tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR, 8'h00);
        rd(tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR, 8'h00);
        wr(tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR, 8'hFF);
        wr(tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR, 8'hE5);
        wr(8'hED, 8'h15);
        rd(tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR, 8'h3F);
        rd(tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR, 8'h25);
        rd(8'hED, 8'h00);
        chk("off1", 8'h3F, {2'b00, off1});
        chk("off2", 8'h25, {2'b00, off2});
    endtask : t_regs
    task t_meas(input logic [5:0] o, input logic [7:0] t);
        wr(tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR, {2'b00, o});
        wr(tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR, {2'b00, ~o});
        @(posedge clk_sys_i) #1;
        raw1 = {1'b1, t};
        raw2 = {1'b1, t};
        @(posedge clk_sys_i) #1;
        raw1.valid = 1'b0;
        raw2.valid = 1'b0;
        chk("v1", 8'h01, {7'h00, out1.valid});
        chk("t1", ref_sum(t, o), out1.temp);
        chk("v2", 8'h01, {7'h00, out2.valid});
        chk("t2", ref_sum(t, ~o), out2.temp);
        @(posedge clk_sys_i) #1;
        chk("hold", ref_sum(t, o), out1.temp);
        chk("pulse", 8'h00, {7'h00, out1.valid});
        chk("hold2", ref_sum(t, ~o), out2.temp);
        chk("pulse2", 8'h00, {7'h00, out2.valid});
    endtask : t_meas
    // clock enable low must freeze registers and readings alike
    task t_freeze;
        wr(tzoa_pkg::TZOA_ZONE1_OFFSET_ADDR, 8'h0A);
        @(posedge clk_sys_i) #1;
        raw1 = {1'b1, 8'h10};
        @(posedge clk_sys_i) #1;
        chk("t1", 8'h1A, out1.temp);
        clk_en_i = 1'b0;
        reg_wr_i = 1'b1;
        reg_wdata_i = 8'h05;
        raw1.temp = 8'h20;
        @(posedge clk_sys_i);
        @(posedge clk_sys_i) #1;
        chk("frz off1", 8'h0A, {2'b00, off1});
        chk("frz t1", 8'h1A, out1.temp);
        chk("frz v1", 8'h01, {7'h00, out1.valid});
        clk_en_i = 1'b1;
        reg_wr_i = 1'b0;
        raw1.valid = 1'b0;
        @(posedge clk_sys_i) #1;
        chk("frz v1", 8'h00, {7'h00, out1.valid});
        chk("frz off1", 8'h0A, {2'b00, off1});
    endtask : t_freeze
    // mid-run reset clears both offsets without a clock edge
    task t_reset;
        @(posedge clk_sys_i) #1;
        arst_n_i = 1'b0;
        #1;
        chk("rst off1", 8'h00, {2'b00, off1});
        chk("rst off2", 8'h00, {2'b00, off2});
        chk("rst rdata", 8'h00, reg_rdata_o);
        chk("rst t1", 8'h00, out1.temp);
        @(posedge clk_sys_i) #1;
        arst_n_i = 1'b1;
        rd(tzoa_pkg::TZOA_ZONE2_OFFSET_ADDR, 8'h00);
        @(posedge clk_sys_i) #1;
        raw2 = {1'b1, 8'h33};
        @(posedge clk_sys_i) #1;
        raw2.valid = 1'b0;
        chk("rst t2", 8'h33, out2.temp);
    endtask : t_reset
    task print_verdict;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1 arst_n_i = 1'b1;
        t_regs();
        for (int i = 0; i < 6; i++) begin
            t_meas(cases[i][13:8], cases[i][7:0]);
        end
        t_freeze();
        t_reset();
        print_verdict();
    end
endmodule : tzoa_offset_tb_top
